// *** sleep_clock_gating_control.sv ***
// sleep mode sequencing, per-peripheral clock gating and analog power enables
// assumes sleep_instr and wake_event are pclk-synchronous; fuses are static straps
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
module sleep_clock_gating_control (
    input  wire logic                                  pclk,
    input  wire logic                                  presetn,
    input  wire logic                                  psel,
    input  wire logic                                  penable,
    input  wire logic                                  pwrite,
    input  wire logic [11:0]                           paddr,
    input  wire logic [31:0]                           pwdata,
    output logic                                       pready,
    output logic [31:0]                                prdata,
    output logic                                       pslverr,
    input  wire logic                                  sleep_instr,
    input  wire logic                                  wake_event,
    input  wire logic                                  crystal_option,
    input  wire logic [1:0]                            brownout_level_fuses,
    input  wire logic                                  adc_start,
    output sleep_clock_pkg::clock_gates_s              gates,
    output sleep_clock_pkg::analog_en_s                analog,
    output logic [sleep_clock_pkg::n_periph-1:0]       periph_reg_access,
    output logic                                       cpu_halted
);
    // ****************************************
    // registers
    // ****************************************
    logic                                  sleep_enable_bit;
    logic [2:0]                            sleep_mode_select;
    logic [sleep_clock_pkg::n_periph-1:0]  power_reduction_bits;
    logic                                  adc_enable;
    logic                                  acmp_disable;
    logic                                  acmp_use_ref;
    logic                                  timer_async;
    logic                                  timer_enable;
    logic                                  adc_was_off;
    logic [3:0]                            wake_count;
    logic [2:0]                            active_mode;
    sleep_clock_pkg::ctrl_state_e          state;
    sleep_clock_pkg::ctrl_state_e          next_state;

    // ****************************************
    // bus decode
    // ****************************************
    wire       access      = psel & penable;
    // writes land only on the edge that completes the transfer; a held access sees pready every other cycle and writes again
    wire       wr          = access & pwrite & pready;
    wire       hit_sleep   = paddr == sleep_clock_pkg::addr_sleep_ctrl;
    wire       hit_pred    = paddr == sleep_clock_pkg::addr_power_red;
    wire       hit_analog  = paddr == sleep_clock_pkg::addr_analog_ctrl;
    wire       hit_status  = paddr == sleep_clock_pkg::addr_status;
    wire       hit_any     = hit_sleep | hit_pred | hit_analog | hit_status;
    wire [2:0] wr_mode     = pwdata[sleep_clock_pkg::mode_lsb +: 3];
    wire       bod_on      = brownout_level_fuses != 2'b11;

    // read mux; reserved bits read zero
    wire [31:0] rd_sleep  = {28'h000_0000, sleep_mode_select, sleep_enable_bit};
    wire [31:0] rd_pred   = {28'h000_0000, power_reduction_bits};
    wire [31:0] rd_analog = {27'h000_0000, timer_enable, timer_async, acmp_use_ref, acmp_disable, adc_enable};
    wire [31:0] rd_status = {28'h000_0000, adc_was_off, active_mode};
    wire [31:0] rd_value  = hit_sleep  ? rd_sleep  :
                            hit_pred   ? rd_pred   :
                            hit_analog ? rd_analog :
                            hit_status ? rd_status : sleep_clock_pkg::unmapped_value;

    // ****************************************
    // sleep entry decision
    // ****************************************
    wire code_ok   = (sleep_mode_select == sleep_clock_pkg::mode_idle)  |
                     (sleep_mode_select == sleep_clock_pkg::mode_noise) |
                     (sleep_mode_select == sleep_clock_pkg::mode_pdown) |
                     (sleep_mode_select == sleep_clock_pkg::mode_psave);
    wire stby_ok   = (sleep_mode_select == sleep_clock_pkg::mode_standby) & crystal_option;
    wire go_sleep  = sleep_instr & sleep_enable_bit & (code_ok | stby_ok);

    // wake waits six cycles only from standby; other modes resume next cycle
    wire is_stby   = active_mode == sleep_clock_pkg::mode_standby;
    always_comb begin
        next_state = state;
        case (state)
            sleep_clock_pkg::st_run: begin
                if (go_sleep) begin
                    next_state = sleep_clock_pkg::st_sleep;
                end
            end
            sleep_clock_pkg::st_sleep: begin
                if (wake_event) begin
                    next_state = is_stby ? sleep_clock_pkg::st_wake : sleep_clock_pkg::st_run;
                end
            end
            sleep_clock_pkg::st_wake: begin
                if (wake_count == sleep_clock_pkg::count_zero) begin
                    next_state = sleep_clock_pkg::st_run;
                end
            end
            default: begin
                next_state = sleep_clock_pkg::st_run;
            end
        endcase
    end

    // ****************************************
    // clock and analog enables per mode
    // ****************************************
    wire asleep    = state != sleep_clock_pkg::st_run;
    wire m_idle    = asleep & (active_mode == sleep_clock_pkg::mode_idle);
    wire m_noise   = asleep & (active_mode == sleep_clock_pkg::mode_noise);
    wire m_psave   = asleep & (active_mode == sleep_clock_pkg::mode_psave);
    wire deep      = asleep & ~m_idle & ~m_noise;
    wire io_run    = ~asleep | m_idle;
    wire t_run     = m_psave & timer_enable;
    wire osc_run   = ~deep | is_stby | (t_run & ~timer_async);
    wire aosc_run  = ~m_psave | (t_run & timer_async);
    wire tsync_run = io_run | (t_run & ~timer_async);
    wire acmp_on   = ~acmp_disable & (~deep | acmp_use_ref);
    wire vref_on   = bod_on | (acmp_on & acmp_use_ref) | adc_enable;

    // ****************************************
    // registered processes
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_enable_bit     <= 1'b0;
            sleep_mode_select    <= 3'b000;
            power_reduction_bits <= '0;
            adc_enable           <= 1'b0;
            acmp_disable         <= 1'b0;
            acmp_use_ref         <= 1'b0;
            timer_async          <= 1'b0;
            timer_enable         <= 1'b0;
        end else if (wr & hit_sleep) begin
            sleep_enable_bit     <= pwdata[sleep_clock_pkg::sleep_enable_pos];
            sleep_mode_select    <= wr_mode;
        end else if (wr & hit_pred) begin
            power_reduction_bits <= pwdata[sleep_clock_pkg::n_periph-1:0];
        end else if (wr & hit_analog) begin
            adc_enable           <= pwdata[sleep_clock_pkg::adc_en_pos];
            acmp_disable         <= pwdata[sleep_clock_pkg::acmp_dis_pos];
            acmp_use_ref         <= pwdata[sleep_clock_pkg::acmp_ref_pos];
            timer_async          <= pwdata[sleep_clock_pkg::timer_async_pos];
            timer_enable         <= pwdata[sleep_clock_pkg::timer_en_pos];
        end
    end

    // adc off flag: set when switched off, cleared by first start after re-enable
    // set wins over clear if both fall in one cycle
    wire adc_off_set = wr & hit_analog & ~pwdata[sleep_clock_pkg::adc_en_pos] & adc_enable;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_was_off <= 1'b0;
        end else if (adc_off_set) begin
            adc_was_off <= 1'b1;
        end else if (adc_start & adc_enable) begin
            adc_was_off <= 1'b0;
        end
    end

    // sequencer state, latched mode, wake counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= sleep_clock_pkg::st_run;
            active_mode <= 3'b000;
            wake_count  <= sleep_clock_pkg::count_zero;
        end else begin
            state <= next_state;
            if (go_sleep && state == sleep_clock_pkg::st_run) begin
                active_mode <= sleep_mode_select;
            end
            if (state == sleep_clock_pkg::st_sleep) begin
                wake_count <= sleep_clock_pkg::wake_count_init;
            end else if (wake_count != sleep_clock_pkg::count_zero) begin
                wake_count <= wake_count - 4'h1;
            end
        end
    end

    // outputs all registered; gate state latched one cycle after the decision
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gates             <= '0;
            analog            <= '0;
            periph_reg_access <= '0;
            cpu_halted        <= 1'b0;
            pready            <= 1'b0;
            prdata            <= 32'h0000_0000;
            pslverr           <= 1'b0;
        end else begin
            gates.cpu_clk_en        <= ~asleep;
            gates.io_clk_en         <= io_run;
            gates.adc_clk_en        <= ~deep;
            gates.main_osc_en       <= osc_run;
            gates.async_osc_en      <= aosc_run;
            gates.timer_sync_clk_en <= tsync_run;
            gates.periph_clk_en     <= {sleep_clock_pkg::n_periph{io_run}} & ~power_reduction_bits;
            periph_reg_access       <= ~power_reduction_bits;
            analog.adc_power        <= adc_enable;
            analog.acmp_power       <= acmp_on;
            analog.bod_power        <= bod_on;
            analog.vref_power       <= vref_on;
            analog.adc_extended     <= adc_was_off;
            cpu_halted              <= asleep;
            pready                  <= access & ~pready;
            prdata                  <= (access & ~pwrite & ~pready) ? rd_value : 32'h0000_0000;
            pslverr                 <= access & ~pready & ~hit_any;
        end
    end
endmodule

// *** sleep_clock_pkg.sv ***
// constants, field layouts and state codes of the sleep and clock-gating control
// assumes a 32-bit apb slave on pclk at 10 MHz and a one-cycle sleep instruction strobe
// Notes on behaviour
// - power-save without async source stops timer oscillator
// - power-save without sync clock stops main clock
// - power-save sync clock only reaches timer in sync mode
// - standby needs code 110 and crystal option
// - standby equals power-down but oscillator runs
// - standby wake resumes after six clock cycles
// - reduction bit stops clock, freezes, blocks registers
// - clearing reduction bit restarts clock, state kept
// - module gating matters only active and idle
// - enabled converter stays enabled in every sleep
// - converter off then on gives extended conversion
// - comparator auto-off except idle and noise-reduction, or when set to use the internal reference
// - comparator on internal reference keeps reference on
// - fuse-enabled brown-out detector stays on in sleep
// - reference on when detector, comparator or converter need
// - no reference users means reference off
// - mode codes 000..011, 110; others reserved
// - sleep instruction acts only with sleep-enable set
// - power-down halts all generated clocks; async_osc_en stays set in power-down
package sleep_clock_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] addr_sleep_ctrl  = 12'h000;
    localparam logic [11:0] addr_power_red   = 12'h004;
    localparam logic [11:0] addr_analog_ctrl = 12'h008;
    localparam logic [11:0] addr_status      = 12'h00c;
    localparam logic [31:0] unmapped_value   = 32'h0000_0000;

    // field positions
    localparam int sleep_enable_pos  = 0;
    localparam int mode_lsb          = 1;
    localparam int n_periph          = 4;
    localparam int adc_en_pos        = 0;
    localparam int acmp_dis_pos      = 1;
    localparam int acmp_ref_pos      = 2;
    localparam int timer_async_pos   = 3;
    localparam int timer_en_pos      = 4;

    // wake delay from standby
    localparam int          standby_wake_cycles = 6;
    localparam logic [3:0]  wake_count_init     = 4'(standby_wake_cycles - 1);
    localparam logic [3:0]  count_zero          = 4'h0;

    // sleep mode select codes
    typedef enum logic [2:0] {
        mode_idle     = 3'b000,
        mode_noise    = 3'b001,
        mode_pdown    = 3'b010,
        mode_psave    = 3'b011,
        mode_standby  = 3'b110
    } sleep_mode_e;

    typedef enum logic [1:0] {
        st_run   = 2'b00,
        st_sleep = 2'b01,
        st_wake  = 2'b10
    } ctrl_state_e;

    // clock gates driven to the clock tree
    typedef struct packed {
        logic                cpu_clk_en;
        logic                io_clk_en;
        logic                adc_clk_en;
        logic                main_osc_en;
        logic                async_osc_en;
        logic                timer_sync_clk_en;
        logic [n_periph-1:0] periph_clk_en;
    } clock_gates_s;

    // analog support enables
    typedef struct packed {
        logic adc_power;
        logic acmp_power;
        logic bod_power;
        logic vref_power;
        logic adc_extended;
    } analog_en_s;
endpackage

// *** sleep_clock_gating_control_monitor.sv ***
// concurrent checks on the ports of the sleep and clock-gating control
// assumes one pclk domain, presetn async active low, fuses static while running
`timescale 1ns/1ps
module sleep_clock_gating_control_monitor (
    input  wire logic                                 pclk,
    input  wire logic                                 presetn,
    input  wire logic                                 sleep_instr,
    input  wire logic [1:0]                           brownout_level_fuses,
    input  wire sleep_clock_pkg::clock_gates_s        gates,
    input  wire sleep_clock_pkg::analog_en_s          analog,
    input  wire logic [sleep_clock_pkg::n_periph-1:0] periph_reg_access,
    input  wire logic                                 cpu_halted
);
    // ********************
    // gating, analog power and sleep entry
    // ********************
    // reset cuts every check, outputs are all zero while it is held
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_blocked_no_clock: assert property ((gates.periph_clk_en & ~periph_reg_access) == '0)
        else $error("clock reaches a peripheral whose registers are blocked");
    a_gating_needs_io: assert property (!gates.io_clk_en |-> gates.periph_clk_en == '0)
        else $error("peripheral clock runs while io clock is stopped");
    a_sync_only_timer: assert property (gates.timer_sync_clk_en && !gates.io_clk_en |-> !gates.cpu_clk_en && !gates.adc_clk_en)
        else $error("sync timer clock leaks to other modules");
    a_pdown_all_off: assert property (cpu_halted && !gates.main_osc_en |-> !(gates.cpu_clk_en || gates.io_clk_en || gates.adc_clk_en))
        else $error("generated clock runs with oscillator stopped");
    a_bod_kept_on: assert property (brownout_level_fuses != 2'b11 && $stable(brownout_level_fuses) |=> analog.bod_power)
        else $error("brown-out detector off although fuses enable it");
    a_bod_needs_ref: assert property (analog.bod_power |-> analog.vref_power)
        else $error("reference off while detector uses it");
    a_ref_off_unused: assert property (!(analog.bod_power || analog.acmp_power || analog.adc_power) |-> !analog.vref_power)
        else $error("reference on without any user");
    a_deep_acmp_ref: assert property (cpu_halted && !gates.adc_clk_en && analog.acmp_power |-> analog.vref_power)
        else $error("comparator kept in deep sleep without its reference");
    a_sleep_has_cause: assert property ($rose(cpu_halted) |-> $past(sleep_instr, 2))
        else $error("cpu halted without a sleep instruction");
endmodule
bind sleep_clock_gating_control sleep_clock_gating_control_monitor i_sleep_clock_gating_control_monitor (
    .pclk(pclk), .presetn(presetn), .sleep_instr(sleep_instr), .brownout_level_fuses(brownout_level_fuses),
    .gates(gates), .analog(analog), .periph_reg_access(periph_reg_access), .cpu_halted(cpu_halted));

// *** sleep_clock_gating_control_tb.sv ***
// self-checking bench for the sleep and clock-gating control
// assumes the apb slave answers on its own pready; outputs packed into one word for probing
`timescale 1ns/1ps
module sleep_clock_gating_control_tb;
    typedef struct { string name; logic [32:0] exp; logic [32:0] mask; } note_s;
    localparam logic [3:0] gate_tab [8] = '{4'h7, 4'h3, 4'h0, 4'h0, 4'hf, 4'hf, 4'hf, 4'hf};
    localparam int         ref_settle_cycles = 4;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, bod;
    logic        sleep_instr = 1'b0, wake_event = 1'b0, crystal_option = 1'b0, adc_start = 1'b0, probe = 1'b0;
    logic        pready, pslverr, cpu_halted;
    logic [1:0]  brownout_level_fuses = 2'b00;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic [3:0]  periph_reg_access, pr;
    sleep_clock_pkg::clock_gates_s gates;
    sleep_clock_pkg::analog_en_s   analog;
    note_s       notes[$];
    int          fails = 0, checks_done = 0, cnt;
    wire  [32:0] obs = {13'h0, cpu_halted, periph_reg_access, analog, gates};
    always #50 pclk = ~pclk;
    sleep_clock_gating_control i_sleep_clock_gating_control (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .sleep_instr(sleep_instr), .wake_event(wake_event), .crystal_option(crystal_option),
        .brownout_level_fuses(brownout_level_fuses), .adc_start(adc_start), .gates(gates), .analog(analog),
        .periph_reg_access(periph_reg_access), .cpu_halted(cpu_halted));
    // ********************
    // shared tasks
    // ********************
    function automatic logic [32:0] st(input logic h, input logic [3:0] a, input logic [4:0] an, input logic [9:0] g);
        return {13'h0, h, a, an, g};
    endfunction
    task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // request held until pready is seen high, then a spare edge so strobes never toggle twice at once
    // no cycle limit here: only the watchdog ends a wait for an answer that never comes
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input string name, input logic [11:0] a, input logic [32:0] exp);
        notes.push_back('{name, exp, {33{1'b1}}});
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic look(input string name, input logic [32:0] exp, input logic [32:0] mask);
        notes.push_back('{name, exp & mask, mask});
        probe <= 1'b1;
        @(posedge pclk);
        probe <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic sleep_now(input logic [2:0] m, input logic en);
        apb(1'b1, sleep_clock_pkg::addr_sleep_ctrl, {28'h000_0000, m, en});
        sleep_instr <= 1'b1;
        @(posedge pclk);
        sleep_instr <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    task automatic wake(output int c);
        c = 0;
        wake_event <= 1'b1;
        @(posedge pclk);
        wake_event <= 1'b0;
        while (cpu_halted !== 1'b0 && c < 40) begin
            @(posedge pclk);
            c++;
        end
    endtask
    task automatic end_of_test;
        // expected answers that never arrived count against the run
        fails += notes.size();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // watcher: oldest note against a read answer or a probe snapshot
    always @(posedge pclk) begin
        if (probe || (pready === 1'b1 && !pwrite)) begin
            note_s n;
            // an answer nobody noted is a mismatch, never a silent pop of an empty queue
            if (notes.size() != 0) begin
                n = notes.pop_front();
            end else begin
                n = '{"unnoted answer", {33{1'b1}}, 33'h0_0000_0000};
            end
            check(n.name, (probe ? obs : {pslverr, prdata}) & n.mask, n.exp);
        end
    end
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        end_of_test();
    end
    // ********************
    // scenarios
    // ********************
    initial begin
        cnt = $urandom(51246);
        brownout_level_fuses = 2'($urandom % 4);
        bod = (brownout_level_fuses != 2'b11);
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        look("run", st(0, 4'hf, {2'b01, bod, bod, 1'b0}, 10'h3ff), st(1, 4'hf, 5'h1f, 10'h3ff));
        rd("ctrl", sleep_clock_pkg::addr_sleep_ctrl, 33'h0_0000_0000);
        rd("reduce", sleep_clock_pkg::addr_power_red, 33'h0_0000_0000);
        rd("analog", sleep_clock_pkg::addr_analog_ctrl, 33'h0_0000_0000);
        rd("unmapped", 12'h010, 33'h1_0000_0000);
        $display("test registers done");
        pr = 4'($urandom);
        apb(1'b1, sleep_clock_pkg::addr_power_red, {28'h000_0000, pr});
        look("gated", st(0, ~pr, 5'h00, {6'h3c, ~pr}), st(0, 4'hf, 5'h00, 10'h00f));
        sleep_now(3'b000, 1'b0);
        look("no enable", st(0, 4'h0, 5'h00, 10'h3c0), st(1, 4'h0, 5'h00, 10'h3c0));
        // every mode code, crystal option off so standby is refused
        for (int m = 0; m < 8; m++) begin
            sleep_now(3'(m), 1'b1);
            look("mode", st(m < 4, 4'h0, {1'b0, gate_tab[m][1], 3'b000}, {gate_tab[m], 2'b00, gate_tab[m][2] ? ~pr : 4'h0}),
                 st(1, 4'h0, 5'h08, 10'h3cf));
            if (cpu_halted === 1'b1) begin
                wake(cnt);
                check("quick wake", 33'(cnt <= 3), 33'h0_0000_0001);
            end
        end
        apb(1'b1, sleep_clock_pkg::addr_power_red, 32'h0000_0000);
        look("ungated", st(0, 4'hf, 5'h00, 10'h00f), st(0, 4'hf, 5'h00, 10'h00f));
        $display("test modes done");
        crystal_option <= 1'b1;
        sleep_now(3'b110, 1'b1);
        look("standby", st(1, 4'h0, 5'h00, 10'h040), st(1, 4'h0, 5'h00, 10'h3cf));
        wake(cnt);
        check("standby wake", 33'(cnt >= 6 && cnt <= 10), 33'h0_0000_0001);
        apb(1'b1, sleep_clock_pkg::addr_analog_ctrl, 32'h0000_0019);
        sleep_now(3'b011, 1'b1);
        look("async", st(1, 4'h0, 5'h10, 10'h020), st(1, 4'h0, 5'h10, 10'h070));
        wake(cnt);
        apb(1'b1, sleep_clock_pkg::addr_analog_ctrl, 32'h0000_0015);
        sleep_now(3'b011, 1'b1);
        look("sync", st(1, 4'h0, 5'h0a, 10'h010), st(1, 4'h0, 5'h0a, 10'h030));
        wake(cnt);
        $display("test power save done");
        apb(1'b1, sleep_clock_pkg::addr_analog_ctrl, 32'h0000_0000);
        apb(1'b1, sleep_clock_pkg::addr_analog_ctrl, 32'h0000_0001);
        look("extended", st(0, 4'h0, 5'h11, 10'h000), st(0, 4'h0, 5'h11, 10'h000));
        rd("status", sleep_clock_pkg::addr_status, 33'h0_0000_000b);
        // reference was just switched back on: let it settle before a conversion uses it
        repeat (ref_settle_cycles) @(posedge pclk);
        adc_start <= 1'b1;
        @(posedge pclk);
        adc_start <= 1'b0;
        @(posedge pclk);
        look("normal", st(0, 4'h0, 5'h10, 10'h000), st(0, 4'h0, 5'h11, 10'h000));
        $display("test converter done");
        end_of_test();
    end
endmodule
